// ---- core/hvs_device.sv ----
// Device end: frame decoder, page buffer, flash and EEPROM erase and program engine.
`timescale 1ns/1ps
module hvs_device (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_reset,
    // Serial link.
    hvs_link_if.dev link,
    // User-side memory view.
    input wire logic [hvs_pkg::FLASH_AW-1:0] i_flash_addr,
    output logic [15:0] o_flash_word,
    input wire logic [hvs_pkg::EE_AW-1:0] i_eeprom_addr,
    output logic [7:0] o_eeprom_byte,
    // Status.
    output logic [1:0] o_lock_bits,
    output logic o_preserve_eeprom_fuse,
    output logic o_busy
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ERASE_FLASH,
        ST_ERASE_EE,
        ST_PROG
    } hvs_dev_state_t;

    logic [15:0] flash_mem [hvs_pkg::FLASH_WORDS];
    logic [7:0] ee_mem [hvs_pkg::EE_BYTES];
    logic [15:0] page_buf [hvs_pkg::PAGE_WORDS];

    logic [2:0] sci_sync_ff;
    logic [1:0] sdi_sync_ff;
    logic [1:0] sii_sync_ff;
    logic sci_rise;
    logic [2:0] bit_cnt_ff;
    logic [7:0] din_sr_ff;
    logic [7:0] iin_sr_ff;
    logic frame_done_ff;
    logic [7:0] frame_data_ff;
    logic [7:0] frame_instr_ff;
    logic [7:0] out_sr_ff;
    logic sdo_ff;
    hvs_dev_state_t state_ff;
    logic [hvs_pkg::FLASH_AW-1:0] sweep_ff;
    logic [15:0] prog_cnt_ff;
    logic write_mode_ff;
    logic [hvs_pkg::FLASH_AW-1:0] addr_ff;
    logic [7:0] data_lo_ff;
    logic [7:0] data_hi_ff;
    logic [1:0] lock_ff;
    logic fuse_ff;
    logic accept;
    logic write_ok;

    // Two flip-flops on every link input; a third stage on the clock finds its rise.
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            sci_sync_ff <= 3'h0;
            sdi_sync_ff <= 2'h0;
            sii_sync_ff <= 2'h0;
        end
        else
        begin
            sci_sync_ff <= {sci_sync_ff[1:0], link.prog_serial_clock_in};
            sdi_sync_ff <= {sdi_sync_ff[0], link.serial_data_in};
            sii_sync_ff <= {sii_sync_ff[0], link.serial_instr_in};
        end
    end

    assign sci_rise = sci_sync_ff[1] & ~sci_sync_ff[2];

    // Shift both input lines in, most significant bit first, on each clock rise.
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            bit_cnt_ff <= 3'h0;
            din_sr_ff <= 8'h00;
            iin_sr_ff <= 8'h00;
            frame_done_ff <= 1'b0;
            frame_data_ff <= 8'h00;
            frame_instr_ff <= 8'h00;
        end
        else
        begin
            frame_done_ff <= 1'b0;
            if (sci_rise)
            begin
                din_sr_ff <= {din_sr_ff[6:0], sdi_sync_ff[1]};
                iin_sr_ff <= {iin_sr_ff[6:0], sii_sync_ff[1]};
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
                if (bit_cnt_ff == 3'(hvs_pkg::FRAME_BITS - 1))
                begin
                    frame_done_ff <= 1'b1;
                    frame_data_ff <= {din_sr_ff[6:0], sdi_sync_ff[1]};
                    frame_instr_ff <= {iin_sr_ff[6:0], sii_sync_ff[1]};
                end
            end
        end
    end

    // A frame is acted on only while no long cycle runs.
    assign accept = frame_done_ff && (state_ff == ST_IDLE);
    assign write_ok = write_mode_ff && lock_ff[0];

    // Command registers: address, data bytes, write mode, lock bits and fuse.
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            write_mode_ff <= 1'b0;
            addr_ff <= '0;
            data_lo_ff <= 8'h00;
            data_hi_ff <= 8'h00;
            lock_ff <= hvs_pkg::LOCK_CLEAR;
            fuse_ff <= hvs_pkg::FUSE_RESET;
        end
        else if (state_ff == ST_ERASE_FLASH && sweep_ff == hvs_pkg::FLASH_AW'(hvs_pkg::FLASH_WORDS - 1))
        begin
            lock_ff <= hvs_pkg::LOCK_CLEAR;
        end
        else if (accept)
        begin
            case (frame_instr_ff)
                hvs_pkg::CMD_NOP: write_mode_ff <= 1'b0;
                hvs_pkg::CMD_WRITE_FLASH: write_mode_ff <= 1'b1;
                hvs_pkg::CMD_LOAD_ADDR_LO: addr_ff[7:0] <= frame_data_ff;
                hvs_pkg::CMD_LOAD_DATA_LO: data_lo_ff <= frame_data_ff;
                hvs_pkg::CMD_LOAD_DATA_HI: data_hi_ff <= frame_data_ff;
                hvs_pkg::CMD_PROG_PAGE: addr_ff[9:8] <= frame_data_ff[1:0];
                hvs_pkg::CMD_WRITE_LOCK: lock_ff <= lock_ff & frame_data_ff[1:0];
                hvs_pkg::CMD_WRITE_FUSE: fuse_ff <= frame_data_ff[0];
                default: ;
            endcase
        end
    end

    // Sequencer for chip erase and page programming.
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            state_ff <= ST_IDLE;
            sweep_ff <= '0;
            prog_cnt_ff <= 16'h0000;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    sweep_ff <= '0;
                    prog_cnt_ff <= 16'h0000;
                    if (accept && frame_instr_ff == hvs_pkg::CMD_CHIP_ERASE)
                        state_ff <= ST_ERASE_FLASH;
                    else if (accept && frame_instr_ff == hvs_pkg::CMD_PROG_PAGE && write_ok)
                        state_ff <= ST_PROG;
                end
                ST_ERASE_FLASH:
                begin
                    sweep_ff <= sweep_ff + 1'b1;
                    if (sweep_ff == hvs_pkg::FLASH_AW'(hvs_pkg::FLASH_WORDS - 1))
                        state_ff <= fuse_ff ? ST_IDLE : ST_ERASE_EE;
                end
                ST_ERASE_EE:
                begin
                    sweep_ff <= sweep_ff + 1'b1;
                    if (sweep_ff == hvs_pkg::FLASH_AW'(hvs_pkg::EE_BYTES - 1))
                        state_ff <= ST_IDLE;
                end
                ST_PROG:
                begin
                    prog_cnt_ff <= prog_cnt_ff + 16'h0001;
                    if (prog_cnt_ff == 16'(hvs_pkg::PAGE_PROG_CYC - 1))
                        state_ff <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Flash array: erase sweep, whole-page commit at the end of the program cycle.
    always_ff @(posedge i_core_clk)
    begin
        if (state_ff == ST_ERASE_FLASH)
            flash_mem[sweep_ff] <= hvs_pkg::ERASED_WORD;
        else if (state_ff == ST_PROG && prog_cnt_ff == 16'(hvs_pkg::PAGE_PROG_CYC - 1))
        begin
            for (int i = 0; i < hvs_pkg::PAGE_WORDS; i++)
                flash_mem[{addr_ff[9:4], 4'(i)}] <= page_buf[i];
        end
        o_flash_word <= flash_mem[i_flash_addr];
    end

    // Page buffer latches one word per latch instruction in write mode.
    always_ff @(posedge i_core_clk)
    begin
        if (accept && frame_instr_ff == hvs_pkg::CMD_LATCH_WORD && write_mode_ff)
            page_buf[addr_ff[3:0]] <= {data_hi_ff, data_lo_ff};
    end

    // EEPROM array: erase sweep unless preserved, byte writes when unlocked.
    always_ff @(posedge i_core_clk)
    begin
        if (state_ff == ST_ERASE_EE)
            ee_mem[sweep_ff[7:0]] <= hvs_pkg::ERASED_BYTE;
        else if (accept && frame_instr_ff == hvs_pkg::CMD_WRITE_EEPROM && lock_ff[0])
            ee_mem[addr_ff[7:0]] <= data_lo_ff;
        o_eeprom_byte <= ee_mem[i_eeprom_addr];
    end

    // Data output: low while busy, high at completion, else shifts on clock rises.
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            sdo_ff <= 1'b1;
            out_sr_ff <= hvs_pkg::ERASED_BYTE;
        end
        else if (state_ff != ST_IDLE)
        begin
            sdo_ff <= 1'b0;
            out_sr_ff <= hvs_pkg::ERASED_BYTE;
        end
        else if (accept && (frame_instr_ff == hvs_pkg::CMD_CHIP_ERASE
                            || (frame_instr_ff == hvs_pkg::CMD_PROG_PAGE && write_ok)))
            sdo_ff <= 1'b0;
        else if (accept && frame_instr_ff == hvs_pkg::CMD_READ_LO)
            out_sr_ff <= flash_mem[addr_ff][7:0];
        else if (accept && frame_instr_ff == hvs_pkg::CMD_READ_HI)
            out_sr_ff <= flash_mem[addr_ff][15:8];
        else if (sci_rise)
        begin
            sdo_ff <= out_sr_ff[7];
            out_sr_ff <= {out_sr_ff[6:0], 1'b1};
        end
        else if (o_busy)
            sdo_ff <= 1'b1;
    end

    // Status outputs from flip-flops.
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            o_lock_bits <= hvs_pkg::LOCK_CLEAR;
            o_preserve_eeprom_fuse <= hvs_pkg::FUSE_RESET;
            o_busy <= 1'b0;
        end
        else
        begin
            o_lock_bits <= lock_ff;
            o_preserve_eeprom_fuse <= fuse_ff;
            o_busy <= (state_ff != ST_IDLE);
        end
    end

    assign link.serial_data_out = sdo_ff;
endmodule : hvs_device

// ---- core/hvs_programmer.sv ----
// Programmer end: sends instruction frames, waits for completion, reads bytes back.
`timescale 1ns/1ps
module hvs_programmer (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_reset,
    // Serial link.
    hvs_link_if.prog link,
    // Command port.
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_instr,
    input wire logic [7:0] i_cmd_data,
    output logic o_cmd_ready,
    output logic o_cmd_refused,
    // Read-back.
    output logic o_rd_valid,
    output logic [7:0] o_rd_data
);
    parameter int FUSE_WAIT_CYC = hvs_pkg::FUSE_WAIT_CYC;

    typedef enum logic [2:0] {
        PS_IDLE,
        PS_LOW,
        PS_HIGH,
        PS_WAIT_SDO,
        PS_WAIT_FUSE
    } hvs_prog_state_t;

    hvs_prog_state_t state_ff;
    logic [1:0] sdo_sync_ff;
    logic [4:0] div_ff;
    logic [2:0] bit_ff;
    logic [7:0] sdi_sr_ff;
    logic [7:0] sii_sr_ff;
    logic [7:0] instr_ff;
    logic [7:0] rd_sr_ff;
    logic reading_ff;
    logic erased_ff;
    logic [31:0] wait_ff;
    logic sci_ff;
    logic half_done;
    logic needs_erase;

    assign half_done = (div_ff == 5'(hvs_pkg::SCI_HALF_CYC - 1));
    assign needs_erase = (i_cmd_instr == hvs_pkg::CMD_WRITE_FLASH)
                         || (i_cmd_instr == hvs_pkg::CMD_WRITE_EEPROM);

    // Data output of the device crosses in through two flip-flops.
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            sdo_sync_ff <= 2'h0;
        else
            sdo_sync_ff <= {sdo_sync_ff[0], link.serial_data_out};
    end

    // Frame engine: clock divider, bit shifting and the completion waits.
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            state_ff <= PS_IDLE;
            div_ff <= 5'h00;
            bit_ff <= 3'h0;
            sdi_sr_ff <= 8'h00;
            sii_sr_ff <= 8'h00;
            instr_ff <= 8'h00;
            rd_sr_ff <= 8'h00;
            reading_ff <= 1'b0;
            erased_ff <= 1'b0;
            wait_ff <= 32'h0000_0000;
            sci_ff <= 1'b0;
            o_cmd_ready <= 1'b0;
            o_cmd_refused <= 1'b0;
            o_rd_valid <= 1'b0;
            o_rd_data <= 8'h00;
        end
        else
        begin
            o_cmd_refused <= 1'b0;
            o_rd_valid <= 1'b0;
            case (state_ff)
                PS_IDLE:
                begin
                    o_cmd_ready <= 1'b1;
                    if (i_cmd_valid && o_cmd_ready)
                    begin
                        o_cmd_ready <= 1'b0;
                        if (needs_erase && !erased_ff)
                            o_cmd_refused <= 1'b1;
                        else
                        begin
                            sdi_sr_ff <= i_cmd_data;
                            sii_sr_ff <= i_cmd_instr;
                            instr_ff <= i_cmd_instr;
                            div_ff <= 5'h00;
                            bit_ff <= 3'h0;
                            state_ff <= PS_LOW;
                        end
                    end
                end
                PS_LOW:
                begin
                    div_ff <= div_ff + 5'h01;
                    if (half_done)
                    begin
                        div_ff <= 5'h00;
                        sci_ff <= 1'b1;
                        state_ff <= PS_HIGH;
                    end
                end
                PS_HIGH:
                begin
                    div_ff <= div_ff + 5'h01;
                    if (half_done)
                    begin
                        div_ff <= 5'h00;
                        sci_ff <= 1'b0;
                        rd_sr_ff <= {rd_sr_ff[6:0], sdo_sync_ff[1]};
                        sdi_sr_ff <= {sdi_sr_ff[6:0], 1'b0};
                        sii_sr_ff <= {sii_sr_ff[6:0], 1'b0};
                        bit_ff <= bit_ff + 3'h1;
                        state_ff <= PS_LOW;
                        if (bit_ff == 3'(hvs_pkg::FRAME_BITS - 1))
                        begin
                            state_ff <= PS_IDLE;
                            wait_ff <= 32'h0000_0000;
                            if (reading_ff)
                            begin
                                reading_ff <= 1'b0;
                                o_rd_valid <= 1'b1;
                                o_rd_data <= {rd_sr_ff[6:0], sdo_sync_ff[1]};
                            end
                            else if (instr_ff == hvs_pkg::CMD_READ_LO
                                     || instr_ff == hvs_pkg::CMD_READ_HI)
                            begin
                                reading_ff <= 1'b1;
                                sii_sr_ff <= hvs_pkg::CMD_SHIFT_OUT;
                                sdi_sr_ff <= 8'h00;
                                instr_ff <= hvs_pkg::CMD_SHIFT_OUT;
                                state_ff <= PS_LOW;
                            end
                            else if (instr_ff == hvs_pkg::CMD_CHIP_ERASE
                                     || instr_ff == hvs_pkg::CMD_PROG_PAGE)
                                state_ff <= PS_WAIT_SDO;
                            else if (instr_ff == hvs_pkg::CMD_WRITE_FUSE)
                                state_ff <= PS_WAIT_FUSE;
                        end
                    end
                end
                PS_WAIT_SDO:
                begin
                    if (sdo_sync_ff[1])
                    begin
                        if (instr_ff == hvs_pkg::CMD_CHIP_ERASE)
                            erased_ff <= 1'b1;
                        state_ff <= PS_IDLE;
                    end
                end
                PS_WAIT_FUSE:
                begin
                    wait_ff <= wait_ff + 32'h0000_0001;
                    if (wait_ff == 32'(FUSE_WAIT_CYC - 1))
                        state_ff <= PS_IDLE;
                end
                default: state_ff <= PS_IDLE;
            endcase
        end
    end

    // Link outputs come straight from the shift registers and the clock flop.
    assign link.prog_serial_clock_in = sci_ff;
    assign link.serial_data_in = sdi_sr_ff[7];
    assign link.serial_instr_in = sii_sr_ff[7];
endmodule : hvs_programmer

// ---- pkg/hvs_link_if.sv ----
// Serial link between the programmer and the device.
`timescale 1ns/1ps
interface hvs_link_if;
    logic prog_serial_clock_in;
    logic serial_data_in;
    logic serial_instr_in;
    logic serial_data_out;

    // Device end samples the three inputs and drives the data output.
    modport dev (
        input prog_serial_clock_in,
        input serial_data_in,
        input serial_instr_in,
        output serial_data_out
    );

    // Programmer end makes the clock and both inputs.
    modport prog (
        output prog_serial_clock_in,
        output serial_data_in,
        output serial_instr_in,
        input serial_data_out
    );
endinterface : hvs_link_if

// ---- pkg/hvs_pkg.sv ----
// Constants, commands and timing for the high-voltage serial erase and program link.
package hvs_pkg;
    // Frame and memory geometry.
    localparam int FRAME_BITS = 8;
    localparam int FLASH_WORDS = 1024;
    localparam int FLASH_AW = 10;
    localparam int PAGE_WORDS = 16;
    localparam int PAGE_AW = 4;
    localparam int EE_BYTES = 256;
    localparam int EE_AW = 8;

    // Instruction codes carried on the instruction line.
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
    localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
    localparam logic [7:0] CMD_LOAD_ADDR_LO = 8'h0C;
    localparam logic [7:0] CMD_LOAD_DATA_LO = 8'h2C;
    localparam logic [7:0] CMD_LOAD_DATA_HI = 8'h3C;
    localparam logic [7:0] CMD_LATCH_WORD = 8'h6C;
    localparam logic [7:0] CMD_PROG_PAGE = 8'h7D;
    localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
    localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
    localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
    localparam logic [7:0] CMD_READ_LO = 8'h68;
    localparam logic [7:0] CMD_READ_HI = 8'h78;
    localparam logic [7:0] CMD_SHIFT_OUT = 8'h0F;

    // Reset values of the nonvolatile control bits and erased memory contents.
    localparam logic [1:0] LOCK_CLEAR = 2'h3;
    localparam logic FUSE_RESET = 1'b0;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

    // Timing at the 125 MHz core clock.
    localparam int CLK_PS = 8000;
    localparam int SCI_HALF_NS = 110;
    localparam int SCI_HALF_CYC = (SCI_HALF_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int PAGE_PROG_NS = 4000;
    localparam int PAGE_PROG_CYC = (PAGE_PROG_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int FUSE_WAIT_US = 2500;
    localparam int FUSE_WAIT_CYC = (FUSE_WAIT_US * 1000) / (CLK_PS / 1000);
endpackage : hvs_pkg

// ---- test/hv_serial_erase_program_test.sv ----
// Testbench joining programmer and device ends over the serial link.
`timescale 1ns/1ps
module hv_serial_erase_program_test;
    logic i_core_clk, i_reset, valid, ready, refused, rd_valid, busy, fuse;
    logic [7:0] instr, data, rd_data, ee_byte, ee_addr;
    logic [15:0] word, first_word;
    logic [hvs_pkg::FLASH_AW-1:0] faddr;
    logic [1:0] lock, first_lock;
    logic got_ref, got_rd, saw_busy;
    int took, miscompares, total_checks, cycles;
    hvs_link_if link();
    hvs_device i_hvs_device (.i_core_clk(i_core_clk), .i_reset(i_reset), .link(link),
        .i_flash_addr(faddr), .o_flash_word(word), .i_eeprom_addr(ee_addr),
        .o_eeprom_byte(ee_byte), .o_lock_bits(lock), .o_preserve_eeprom_fuse(fuse),
        .o_busy(busy));
    hvs_programmer #(.FUSE_WAIT_CYC(50)) i_hvs_programmer (.i_core_clk(i_core_clk),
        .i_reset(i_reset), .link(link), .i_cmd_valid(valid), .i_cmd_instr(instr),
        .i_cmd_data(data), .o_cmd_ready(ready), .o_cmd_refused(refused),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data));
    hvs_link_asserts i_hvs_link_asserts (.i_core_clk(i_core_clk), .i_reset(i_reset),
        .prog_serial_clock_in(link.prog_serial_clock_in),
        .serial_data_in(link.serial_data_in), .serial_instr_in(link.serial_instr_in),
        .serial_data_out(link.serial_data_out), .o_busy(busy));
    // Clock generator at 125 MHz.
    initial
    begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end
    // Compare one value and count it.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Hand one instruction to the programmer and watch until it is idle again.
    task automatic send(input logic [7:0] ins, input logic [7:0] dat);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 3000)
        begin
            @(negedge i_core_clk);
            n++;
        end
        @(posedge i_core_clk);
        valid <= 1'b1;
        instr <= ins;
        data <= dat;
        @(posedge i_core_clk);
        valid <= 1'b0;
        got_ref = 0;
        got_rd = 0;
        saw_busy = 0;
        took = 0;
        do
        begin
            @(negedge i_core_clk);
            took++;
            if (refused === 1'b1) got_ref = 1;
            if (rd_valid === 1'b1) got_rd = 1;
            if (busy === 1'b1 && !saw_busy)
            begin
                saw_busy = 1;
                first_lock = lock;
                first_word = word;
            end
        end while ((ready !== 1'b1 || took < 2) && took < 3000);
    endtask : send
    // Print the counts and the verdict, then stop.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    // Writing flash before any erase must be turned away.
    task automatic t_refuse();
        send(hvs_pkg::CMD_WRITE_FLASH, 8'h00);
        chk("refusal", 16'h0001, {15'h0000, got_ref});
        $display("test refuse done");
    endtask : t_refuse
    // Locked part with preserve fuse set: erase keeps EEPROM and fuse, clears locks last.
    task automatic t_erase_keep();
        send(hvs_pkg::CMD_WRITE_LOCK, 8'h00);
        chk("lock set", 16'h0000, {14'h0000, lock});
        send(hvs_pkg::CMD_WRITE_FUSE, 8'h01);
        chk("fuse wait", 16'h0001, {15'h0000, took >= 224 + 50});
        chk("fuse set", 16'h0001, {15'h0000, fuse});
        send(hvs_pkg::CMD_CHIP_ERASE, 8'h00);
        chk("lock during erase", 16'h0000, {14'h0000, first_lock});
        chk("lock after erase", 16'h0003, {14'h0000, lock});
        chk("fuse after erase", 16'h0001, {15'h0000, fuse});
        chk("flash erased", hvs_pkg::ERASED_WORD, word);
        chk("eeprom kept", 16'h0001, {15'h0000, ee_byte !== 8'hFF});
        send(hvs_pkg::CMD_NOP, 8'h00);
        $display("test erase keep done");
    endtask : t_erase_keep
    // Erase with the fuse cleared wipes the EEPROM; a written byte survives a kept erase.
    task automatic t_erase_full();
        send(hvs_pkg::CMD_WRITE_FUSE, 8'h00);
        send(hvs_pkg::CMD_CHIP_ERASE, 8'h00);
        chk("eeprom erased", 16'h00FF, {8'h00, ee_byte});
        chk("fuse clear", 16'h0000, {15'h0000, fuse});
        send(hvs_pkg::CMD_NOP, 8'h00);
        send(hvs_pkg::CMD_LOAD_ADDR_LO, 8'h05);
        send(hvs_pkg::CMD_LOAD_DATA_LO, 8'h5A);
        send(hvs_pkg::CMD_WRITE_EEPROM, 8'h00);
        chk("eeprom written", 16'h005A, {8'h00, ee_byte});
        send(hvs_pkg::CMD_WRITE_FUSE, 8'h01);
        send(hvs_pkg::CMD_CHIP_ERASE, 8'h00);
        chk("eeprom byte kept", 16'h005A, {8'h00, ee_byte});
        send(hvs_pkg::CMD_NOP, 8'h00);
        $display("test erase full done");
    endtask : t_erase_full
    // Fill the last page, commit it, then read one word back over the link.
    task automatic t_page();
        send(hvs_pkg::CMD_WRITE_FLASH, 8'h00);
        chk("write accepted", 16'h0000, {15'h0000, got_ref});
        for (int i = 0; i < 16; i++)
        begin
            send(hvs_pkg::CMD_LOAD_ADDR_LO, 8'hF0 | 8'(i));
            send(hvs_pkg::CMD_LOAD_DATA_LO, {4'hC, 4'(i)});
            send(hvs_pkg::CMD_LOAD_DATA_HI, {4'(i), 4'h3});
            send(hvs_pkg::CMD_LATCH_WORD, 8'h00);
        end
        send(hvs_pkg::CMD_PROG_PAGE, 8'h03);
        chk("no early commit", hvs_pkg::ERASED_WORD, first_word);
        chk("done level", 16'h0001, {15'h0000, link.serial_data_out});
        for (int i = 0; i < 16; i++)
        begin
            @(posedge i_core_clk);
            faddr <= 10'h3F0 + 10'(i);
            @(posedge i_core_clk);
            @(negedge i_core_clk);
            chk("page word", {4'(i), 4'h3, 4'hC, 4'(i)}, word);
        end
        send(hvs_pkg::CMD_NOP, 8'h00);
        send(hvs_pkg::CMD_LOAD_ADDR_LO, 8'hF5);
        send(hvs_pkg::CMD_READ_LO, 8'h00);
        chk("read low", 16'h01C5, {7'h00, got_rd, rd_data});
        send(hvs_pkg::CMD_READ_HI, 8'h00);
        chk("read high", 16'h0153, {7'h00, got_rd, rd_data});
        $display("test page done");
    endtask : t_page
    // Hang guard, well above the expected run length.
    always @(posedge i_core_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    // Main sequence.
    initial
    begin
        i_reset = 1'b1;
        valid = 1'b0;
        instr = 8'h00;
        data = 8'h00;
        faddr = 10'h3F0;
        ee_addr = 8'h05;
        repeat (3) @(posedge i_core_clk);
        i_reset <= 1'b0;
        t_refuse();
        t_erase_keep();
        t_erase_full();
        t_page();
        give_verdict();
    end
endmodule : hv_serial_erase_program_test

// ---- test/hvs_link_asserts.sv ----
// Checker for the serial link wires and the device completion flag.
`timescale 1ns/1ps
module hvs_link_asserts (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_reset,
    // Link wires and device status.
    input wire logic prog_serial_clock_in,
    input wire logic serial_data_in,
    input wire logic serial_instr_in,
    input wire logic serial_data_out,
    input wire logic o_busy
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    logic sci_ff, sdi_ff, sii_ff;
    logic [7:0] hi_ff, lo_ff, age_ff, rise_ff;
    logic [11:0] busy_ff;
    logic rise;
    assign rise = prog_serial_clock_in && !sci_ff;
    // Ages of the clock phases, of the data bits and of the last clock rise.
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            sci_ff <= 1'b0;
            sdi_ff <= serial_data_in;
            sii_ff <= serial_instr_in;
            hi_ff <= 8'h00;
            lo_ff <= 8'h00;
            age_ff <= 8'h00;
            rise_ff <= 8'hFF;
        end
        else
        begin
            sci_ff <= prog_serial_clock_in;
            sdi_ff <= serial_data_in;
            sii_ff <= serial_instr_in;
            hi_ff <= prog_serial_clock_in ? hi_ff + {7'h00, hi_ff != 8'hFF} : 8'h00;
            lo_ff <= !prog_serial_clock_in ? lo_ff + {7'h00, lo_ff != 8'hFF} : 8'h00;
            age_ff <= (serial_data_in != sdi_ff || serial_instr_in != sii_ff) ? 8'h00
                : age_ff + {7'h00, age_ff != 8'hFF};
            rise_ff <= rise ? 8'h00 : rise_ff + {7'h00, rise_ff != 8'hFF};
        end
    end
    // Length of the current busy spell; long spells would hide a stuck engine.
    always_ff @(posedge i_core_clk)
    begin
        busy_ff <= (i_reset || !o_busy) ? 12'h000 : busy_ff + 12'h001;
    end
    a_sdo_low_busy: assert property (o_busy && $past(o_busy) |-> !serial_data_out)
        else $error("data out high while busy");
    a_sdo_high_done: assert property ($fell(o_busy) |-> ##[1:2] serial_data_out)
        else $error("data out not high after completion");
    a_clk_high_width: assert property (!prog_serial_clock_in && sci_ff |->
        hi_ff >= hvs_pkg::SCI_HALF_CYC - 1) else $error("clock high too short");
    a_clk_low_width: assert property (rise |-> lo_ff >= hvs_pkg::SCI_HALF_CYC - 1)
        else $error("clock low too short");
    a_data_setup_rise: assert property (rise |-> age_ff >= 8'h06)
        else $error("data changed too close before clock rise");
    a_data_hold_rise: assert property (rise |-> ##1
        ($stable(serial_data_in) && $stable(serial_instr_in))[*6])
        else $error("data changed too soon after clock rise");
    a_sdo_moves_rise: assert property ($changed(serial_data_out) |-> (rise_ff < 8'h0C) ||
        (o_busy != $past(o_busy))) else $error("data out moved off a rise");
    a_busy_bounded_len: assert property (busy_ff <= 12'h514)
        else $error("busy spell too long");
    a_busy_min_len: assert property ($fell(o_busy) |-> busy_ff >= 12'h1F0)
        else $error("busy spell too short");
    c_long_erase: cover property ($fell(o_busy) && busy_ff > 12'h3E8);
    c_page_prog: cover property ($fell(o_busy) && busy_ff < 12'h3E8);
    c_done_rise: cover property ($rose(serial_data_out));
endmodule : hvs_link_asserts
